// [hw/adc_seq_pkg.sv]
// Constants and carrier types for the serial converter sequencer
`default_nettype none

package adc_seq_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_PERIOD_NS = 100;
  localparam int OVERHEAD_NS = 100;
  localparam int OVERHEAD_CYCLES_RAW = (OVERHEAD_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int OVERHEAD_CYCLES = (OVERHEAD_CYCLES_RAW < 1) ? 1 : OVERHEAD_CYCLES_RAW;
  localparam logic [3:0] OVERHEAD_LAST = 4'(OVERHEAD_CYCLES - 1);

  // ----------------------------------------------------------------
  // Frame layout, counted in serial clock rising edges
  // ----------------------------------------------------------------
  localparam int RESULT_BITS = 12;
  localparam int WORD_BITS = 16;
  localparam logic [5:0] SAMPLE_FIRST_EDGE = 6'h05;
  localparam logic [5:0] SAMPLE_LAST_EDGE = 6'h10;
  localparam logic [5:0] WORD_LAST_EDGE = 6'h10;
  localparam logic [5:0] MUX_RESET_MIN = 6'h04;
  localparam logic [5:0] MUX_RESET_MAX = 6'h07;
  localparam logic [5:0] EDGE_COUNT_MAX = 6'h3f;

  // ----------------------------------------------------------------
  // Conversion
  // ----------------------------------------------------------------
  localparam logic [3:0] CONV_STEPS = 4'he;
  localparam logic [3:0] CONV_LAST_STEP = 4'hd;
  localparam logic [11:0] CODE_FULL_SCALE = 12'hfff;
  localparam logic [11:0] CODE_ZERO_SCALE = 12'h000;
  localparam logic [11:0] CODE_FIRST_TRIAL = 12'h800;
  localparam logic [3:0] PAD_BITS = 4'h0;

  // ----------------------------------------------------------------
  // Result queue
  // ----------------------------------------------------------------
  localparam int QUEUE_DEPTH = 4;

  typedef struct packed {
    logic valid;
    logic [RESULT_BITS-1:0] code;
  } result_word_t;

  localparam int RESULT_WORD_BITS = $bits(result_word_t);

  typedef enum logic [2:0] {
    ST_POWER_DOWN,
    ST_ACQUIRE,
    ST_CONVERT,
    ST_OVERHEAD,
    ST_STORE,
    ST_DONE
  } seq_state_t;

endpackage

`default_nettype wire

// [hw/result_fifo.sv]
// Small valid/ready FIFO holding converted result words
`timescale 1ns/1ps
`default_nettype none

module result_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] inData, // Word to store
  input wire logic inValid, // Producer has a word
  output logic inReady, // Room for a word
  output logic [WIDTH-1:0] outData, // Oldest word
  output logic outValid, // Queue not empty
  input wire logic outReady // Consumer takes the word
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [PW:0] count_reg;
  logic doWrite;
  logic doRead;

  // ----------------------------------------------------------------
  // Handshake decode
  // ----------------------------------------------------------------
  assign inReady = (count_reg != (PW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  // Storage has no reset; only pointers and the count carry state
  always_ff @(posedge ref_clk)
  begin
    if (doWrite)
      mem[wrPtr_reg] <= inData;
  end

  // Pointers wrap naturally because depth is a power of two
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (doWrite)
        wrPtr_reg <= wrPtr_reg + 1'b1;
      if (doRead)
        rdPtr_reg <= rdPtr_reg + 1'b1;
      if (doWrite && !doRead)
        count_reg <= count_reg + 1'b1;
      else if (doRead && !doWrite)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule

`default_nettype wire

// [hw/serial_adc_conversion_sequencer.sv]
// Sequencer for a serially clocked 12-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none

module serial_adc_conversion_sequencer (
  input wire logic ref_clk, // System clock, 10 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic serialClock, // Host serial clock, sampled
  input wire logic selectOrFrameSyncN, // Select or frame sync, active low
  input wire logic dspFrameMode, // Select pin driven by a DSP frame sync
  input wire logic dualVariant, // Dual-input variant strap
  input wire logic pseudoDiffVariant, // Pseudo-differential variant strap
  input wire logic comparatorHigh, // Held sample at or above DAC level
  input wire logic inputAboveRef, // Input at or above reference
  input wire logic inputBelowGround, // Input at or below ground
  output logic serialResultOut, // Serial result data
  output logic serialResultOutEn, // Drive enable for the result pin
  output logic resultInvalid, // Word now shifting is invalid
  output logic sampleEnable, // Sampling switch closed
  output logic [11:0] dacCode, // Trial code for the DAC
  output logic channelSelect, // Selected input, 0 is channel zero
  output logic endOfConversion, // Internal end of conversion
  output logic powerDown // Low-power state
);
  import adc_seq_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One SAR decision: keep or drop the trial bit, then try the next one
  function automatic logic [11:0] sar_step(input logic [11:0] code, input logic [3:0] step,
                                           input logic keep);
    logic [11:0] res;
    logic [3:0] idx;
    res = code;
    idx = 4'(4'd11 - step);
    res[idx] = keep;
    if (idx != 4'h0)
      res[idx - 4'h1] = 1'b1;
    return res;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  seq_state_t state_reg, state_next;
  logic sclkPrev_reg;
  logic selPrev_reg;
  logic [5:0] edgeCount_reg, edgeCount_next;
  logic convPhase_reg, convPhase_next;
  logic [3:0] convStep_reg, convStep_next;
  logic [3:0] overhead_reg, overhead_next;
  logic [11:0] sarCode_reg, sarCode_next;
  logic [15:0] shift_reg, shift_next;
  logic outEn_reg, outEn_next;
  logic invalid_reg, invalid_next;
  logic sample_reg, sample_next;
  logic channel_reg, channel_next;
  logic eoc_reg, eoc_next;
  logic power_reg, power_next;
  logic pushPending_reg, pushPending_next;
  result_word_t pushWord_reg, pushWord_next;

  // ----------------------------------------------------------------
  // Edge decode of the sampled pins
  // ----------------------------------------------------------------
  logic sclkRise, sclkFall, selFall, selRise;
  logic fallingShift, shiftEdge, convClockTick, running;
  logic muxResetWindow;
  logic [11:0] clampedCode;
  result_word_t queueOut;
  logic queueOutValid, queueInReady, queuePop;

  assign sclkRise = serialClock && !sclkPrev_reg;
  assign sclkFall = !serialClock && sclkPrev_reg;
  assign selFall = !selectOrFrameSyncN && selPrev_reg;
  assign selRise = selectOrFrameSyncN && !selPrev_reg;
  // Frame-sync drive and the two-pin variants shift on the falling edge
  assign fallingShift = dspFrameMode || dualVariant || pseudoDiffVariant;
  assign shiftEdge = fallingShift ? sclkFall : sclkRise;
  // Conversion clock completes once per two serial clock rising edges
  assign convClockTick = sclkRise && convPhase_reg;
  assign running = (state_reg == ST_ACQUIRE) || (state_reg == ST_CONVERT) ||
                   (state_reg == ST_OVERHEAD);
  assign muxResetWindow = (edgeCount_reg >= MUX_RESET_MIN) &&
                          (edgeCount_reg <= MUX_RESET_MAX);
  assign clampedCode = inputAboveRef ? CODE_FULL_SCALE :
                       inputBelowGround ? CODE_ZERO_SCALE : sarCode_reg;
  assign queuePop = selFall && queueOutValid;

  // ----------------------------------------------------------------
  // Result queue between converter and shifter
  // ----------------------------------------------------------------
  // A full queue holds the finished result back, which stalls completion
  result_fifo #(
    .WIDTH(RESULT_WORD_BITS),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .inData(pushWord_reg),
    .inValid(pushPending_reg),
    .inReady(queueInReady),
    .outData(queueOut),
    .outValid(queueOutValid),
    .outReady(queuePop)
  );

  // ----------------------------------------------------------------
  // Sequencer next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    edgeCount_next = edgeCount_reg;
    convPhase_next = convPhase_reg;
    convStep_next = convStep_reg;
    overhead_next = overhead_reg;
    sarCode_next = sarCode_reg;
    shift_next = shift_reg;
    outEn_next = outEn_reg;
    invalid_next = invalid_reg;
    sample_next = sample_reg;
    channel_next = channel_reg;
    eoc_next = eoc_reg;
    power_next = power_reg;
    pushPending_next = pushPending_reg && !queueInReady;
    pushWord_next = pushWord_reg;

    // Count serial clock rising edges of the active cycle, saturating
    if (sclkRise && edgeCount_reg != EDGE_COUNT_MAX)
      edgeCount_next = edgeCount_reg + 6'h01;

    // Sampling window covers rising edges five through sixteen
    if (sclkRise && state_reg == ST_ACQUIRE)
    begin
      if (edgeCount_reg == SAMPLE_FIRST_EDGE - 6'h01)
        sample_next = 1'b1;
      if (edgeCount_reg == SAMPLE_LAST_EDGE - 6'h01)
        sample_next = 1'b0;
    end

    // Output shifter, MSB first; pin released after the last bit
    if (shiftEdge && outEn_reg)
      shift_next = {shift_reg[14:0], 1'b0};
    if (sclkRise && edgeCount_reg == WORD_LAST_EDGE)
      outEn_next = 1'b0;

    unique case (state_reg)
      ST_POWER_DOWN, ST_DONE:
        ;
      ST_ACQUIRE:
        // Conversion starts only once the sixteenth edge has passed
        if (sclkRise && edgeCount_reg == WORD_LAST_EDGE - 6'h01)
        begin
          state_next = ST_CONVERT;
          convPhase_next = 1'b0;
          convStep_next = 4'h0;
          sarCode_next = CODE_FIRST_TRIAL;
        end
      ST_CONVERT:
      begin
        if (sclkRise)
          convPhase_next = !convPhase_reg;
        if (convClockTick)
        begin
          if (convStep_reg < 4'(RESULT_BITS))
            sarCode_next = sar_step(sarCode_reg, convStep_reg, comparatorHigh);
          convStep_next = convStep_reg + 4'h1;
          if (convStep_reg == CONV_LAST_STEP)
          begin
            state_next = ST_OVERHEAD;
            overhead_next = '0;
          end
        end
      end
      ST_OVERHEAD:
        // Fixed overhead in system clocks, independent of the serial clock
        if (overhead_reg == OVERHEAD_LAST)
          state_next = ST_STORE;
        else
          overhead_next = overhead_reg + 4'h1;
      ST_STORE:
        // Wait for room in the queue before declaring completion
        if (!pushPending_next)
        begin
          state_next = ST_DONE;
          eoc_next = 1'b1;
          power_next = 1'b1;
          pushPending_next = 1'b1;
          pushWord_next = '{valid: 1'b1, code: clampedCode};
        end
    endcase

    // Rising select: abort an unfinished conversion, or step the channel
    if (selRise)
    begin
      sample_next = 1'b0;
      outEn_next = 1'b0;
      if (running || state_reg == ST_STORE)
      begin
        state_next = ST_POWER_DOWN;
        power_next = 1'b1;
        if (!pushPending_next)
        begin
          pushPending_next = 1'b1;
          pushWord_next = '{valid: 1'b0, code: CODE_ZERO_SCALE};
        end
        if (dualVariant && state_reg == ST_ACQUIRE && muxResetWindow)
          channel_next = 1'b0;
      end
      else if (state_reg == ST_DONE)
      begin
        state_next = ST_POWER_DOWN;
        if (dualVariant)
          channel_next = !channel_reg;
      end
    end

    // Falling select wakes the core and loads the previous result
    if (selFall)
    begin
      state_next = ST_ACQUIRE;
      power_next = 1'b0;
      eoc_next = 1'b0;
      edgeCount_next = '0;
      sample_next = 1'b0;
      outEn_next = 1'b1;
      if (queueOutValid)
      begin
        shift_next = {queueOut.code, PAD_BITS};
        invalid_next = !queueOut.valid;
      end
      else
      begin
        shift_next = '0;
        invalid_next = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Pin history for edge detection; inputs are already in this domain
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      sclkPrev_reg <= 1'b0;
      selPrev_reg <= 1'b1;
    end
    else
    begin
      sclkPrev_reg <= serialClock;
      selPrev_reg <= selectOrFrameSyncN;
    end
  end

  // Sequencer control; comes up powered down on channel zero
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_POWER_DOWN;
      edgeCount_reg <= '0;
      convPhase_reg <= 1'b0;
      convStep_reg <= '0;
      overhead_reg <= '0;
      channel_reg <= 1'b0;
      eoc_reg <= 1'b0;
      power_reg <= 1'b1;
      pushPending_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      edgeCount_reg <= edgeCount_next;
      convPhase_reg <= convPhase_next;
      convStep_reg <= convStep_next;
      overhead_reg <= overhead_next;
      channel_reg <= channel_next;
      eoc_reg <= eoc_next;
      power_reg <= power_next;
      pushPending_reg <= pushPending_next;
    end
  end

  // Datapath registers that feed the pins and the result queue
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      sarCode_reg <= '0;
      shift_reg <= '0;
      outEn_reg <= 1'b0;
      invalid_reg <= 1'b1;
      sample_reg <= 1'b0;
      pushWord_reg <= '0;
    end
    else
    begin
      sarCode_reg <= sarCode_next;
      shift_reg <= shift_next;
      outEn_reg <= outEn_next;
      invalid_reg <= invalid_next;
      sample_reg <= sample_next;
      pushWord_reg <= pushWord_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from a flip-flop
  // ----------------------------------------------------------------
  assign serialResultOut = shift_reg[WORD_BITS-1];
  assign serialResultOutEn = outEn_reg;
  assign resultInvalid = invalid_reg;
  assign sampleEnable = sample_reg;
  assign dacCode = sarCode_reg;
  assign channelSelect = channel_reg;
  assign endOfConversion = eoc_reg;
  assign powerDown = power_reg;

endmodule

`default_nettype wire

// [tb/adc_seq_sva.sv]
// Concurrent checks on the sequencer's ports
`timescale 1ns/1ps
`default_nettype none

module adc_seq_sva (
  input wire logic ref_clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic serialClock, // Host serial clock
  input wire logic selectOrFrameSyncN, // Select, active low
  input wire logic dspFrameMode, // Frame sync strap
  input wire logic dualVariant, // Dual-input strap
  input wire logic pseudoDiffVariant, // Pseudo-differential strap
  input wire logic comparatorHigh, // Comparator decision
  input wire logic inputAboveRef, // Input over reference
  input wire logic inputBelowGround, // Input under ground
  input wire logic serialResultOut, // Serial data
  input wire logic serialResultOutEn, // Data drive enable
  input wire logic resultInvalid, // Word invalid
  input wire logic sampleEnable, // Sampling window
  input wire logic [11:0] dacCode, // Trial code
  input wire logic channelSelect, // Selected input
  input wire logic endOfConversion, // End of conversion
  input wire logic powerDown // Low-power state
);
  logic selPrev, sclkPrev, roseD, fellD;
  logic [5:0] riseCnt;
  logic [5:0] riseNext;
  logic selFall, selRise, sclkRise, shiftFall;

  // ----------------------------------------------------------------
  // Edge tracking, same sampling as the device
  // ----------------------------------------------------------------
  assign selFall = selPrev && !selectOrFrameSyncN;
  assign selRise = !selPrev && selectOrFrameSyncN;
  assign sclkRise = serialClock && !sclkPrev;
  assign shiftFall = dspFrameMode || dualVariant || pseudoDiffVariant;
  // Saturates so a stuck clock cannot wrap the count
  assign riseNext = selFall ? 6'h00 :
    (!selectOrFrameSyncN && sclkRise && riseCnt != 6'h3f) ? riseCnt + 6'h01 : riseCnt;

  // Counter of rising serial edges in the active cycle
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      selPrev <= 1'b1;
      sclkPrev <= 1'b0;
      roseD <= 1'b0;
      fellD <= 1'b0;
      riseCnt <= 6'h00;
    end
    else
    begin
      selPrev <= selectOrFrameSyncN;
      sclkPrev <= serialClock;
      roseD <= sclkRise;
      fellD <= !serialClock && sclkPrev;
      riseCnt <= riseNext;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  wake_on_select_a: assert property (selFall |=> !powerDown && serialResultOutEn)
    else $error("no wake after select fall");
  rise_shutdown_a: assert property (selRise |=>
    powerDown && !serialResultOutEn)
    else $error("no shutdown after select rise");
  done_sleep_a: assert property ($rose(endOfConversion) |-> ##[0:1] powerDown)
    else $error("no power down after conversion");
  sample_start_a: assert property ($rose(sampleEnable) |-> riseCnt == 6'h05)
    else $error("sampling opened at wrong edge");
  sample_end_a: assert property ($fell(sampleEnable) && !selectOrFrameSyncN |->
    riseCnt == 6'h10)
    else $error("sampling closed at wrong edge");
  conv_length_a: assert property ($rose(endOfConversion) |->
    $past(riseCnt) >= 6'h2c)
    else $error("conversion ended too early");
  conv_prompt_a: assert property (riseCnt == 6'h2c && $past(riseCnt) == 6'h2b |->
    ##[0:8] (endOfConversion || selectOrFrameSyncN))
    else $error("conversion did not end");
  word_end_a: assert property (riseCnt >= 6'h11 |-> !serialResultOutEn)
    else $error("data driven past the word");
  shift_edge_a: assert property (serialResultOutEn && $past(serialResultOutEn) &&
    $changed(serialResultOut) |-> (shiftFall ? fellD : roseD))
    else $error("data changed off its shift edge");
  mux_reset_a: assert property (dualVariant && selRise && !endOfConversion &&
    riseCnt >= 6'h04 && riseCnt <= 6'h07 |=> !channelSelect)
    else $error("short cycle kept channel");
  mux_toggle_a: assert property (dualVariant && selRise && endOfConversion |=>
    channelSelect != $past(channelSelect))
    else $error("channel did not toggle");

  // Main scenarios reached
  cover property ($rose(endOfConversion));
  cover property (selRise && !endOfConversion && riseCnt >= 6'h10);
  cover property (dualVariant && selRise && riseCnt == 6'h05);
endmodule

bind serial_adc_conversion_sequencer adc_seq_sva chk (.ref_clk, .reset_n, .serialClock,
  .selectOrFrameSyncN, .dspFrameMode, .dualVariant, .pseudoDiffVariant, .comparatorHigh,
  .inputAboveRef, .inputBelowGround, .serialResultOut, .serialResultOutEn, .resultInvalid,
  .sampleEnable, .dacCode, .channelSelect, .endOfConversion, .powerDown);
`default_nettype wire

// [tb/serial_host.sv]
// Host serial port model: select, serial clock and word capture
`timescale 1ns/1ps
`default_nettype none

module serial_host (
  input wire logic ref_clk, // System clock
  input wire logic serialResultOut, // Result data pin
  input wire logic serialResultOutEn, // Result pin drive enable
  input wire logic fallShift, // Device shifts on falling clock
  output logic serialClock, // Serial clock to device
  output logic selectOrFrameSyncN // Select, active low
);
  // Two ref cycles a level keeps the clock well under its limit
  localparam int HALF = 2;
  logic lastBit;
  logic pin;

  initial
  begin
    serialClock = 1'b0;
    selectOrFrameSyncN = 1'b1;
    lastBit = 1'b0;
  end

  // Released pin reads the inverse of its last driven level
  assign pin = serialResultOutEn ? serialResultOut : ~lastBit;
  always @(posedge ref_clk)
    if (serialResultOutEn) lastBit <= serialResultOut;

  // Clock stands low outside frames; bits taken just before each shift edge
  task automatic start_frame(input int edges, output logic [15:0] word);
    int n;
    word = 16'h0000;
    @(negedge ref_clk);
    selectOrFrameSyncN = 1'b0;
    // Shared pin: the select fall is the frame sync, so no separate rise to space
    repeat (HALF + 1) @(negedge ref_clk);
    for (n = 0; n < edges; n++)
    begin
      if (!fallShift && n < 16) word = {word[14:0], pin};
      serialClock = 1'b1;
      repeat (HALF) @(negedge ref_clk);
      if (fallShift && n < 16) word = {word[14:0], pin};
      serialClock = 1'b0;
      repeat (HALF) @(negedge ref_clk);
    end
  endtask

  // Select high time kept above its minimum
  task automatic end_frame();
    selectOrFrameSyncN = 1'b1;
    repeat (HALF + 1) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking testbench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none

module tb;
  import adc_seq_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic dspFrameMode = 1'b0, dualVariant = 1'b0, pseudoDiffVariant = 1'b0;
  logic comparatorHigh = 1'b0, inputAboveRef = 1'b0, inputBelowGround = 1'b0;
  logic serialClock, selectOrFrameSyncN;
  logic serialResultOut, serialResultOutEn, resultInvalid, sampleEnable;
  logic channelSelect, endOfConversion, powerDown;
  logic [11:0] dacCode;
  logic [11:0] vin = 12'h000;
  logic [17:0] expQ[$];
  int num_errors = 0;
  int cmp_count = 0;

  always #50 ref_clk = ~ref_clk;

  serial_adc_conversion_sequencer uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .serialClock(serialClock), .selectOrFrameSyncN(selectOrFrameSyncN),
    .dspFrameMode(dspFrameMode), .dualVariant(dualVariant),
    .pseudoDiffVariant(pseudoDiffVariant), .comparatorHigh(comparatorHigh),
    .inputAboveRef(inputAboveRef), .inputBelowGround(inputBelowGround),
    .serialResultOut(serialResultOut), .serialResultOutEn(serialResultOutEn),
    .resultInvalid(resultInvalid), .sampleEnable(sampleEnable), .dacCode(dacCode),
    .channelSelect(channelSelect), .endOfConversion(endOfConversion), .powerDown(powerDown));

  serial_host host (.ref_clk(ref_clk), .serialResultOut(serialResultOut),
    .serialResultOutEn(serialResultOutEn),
    .fallShift(dspFrameMode | dualVariant | pseudoDiffVariant),
    .serialClock(serialClock), .selectOrFrameSyncN(selectOrFrameSyncN));

  // Ideal comparator against the held input
  always @(negedge ref_clk) comparatorHigh <= (vin >= dacCode);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One cycle: reads the oldest queued word, queues this cycle's outcome
  task automatic frame(input int edges, input logic [11:0] v, input logic hi, lo);
    logic [17:0] e;
    logic [15:0] w;
    logic ch;
    vin = v;
    inputAboveRef = hi;
    inputBelowGround = lo;
    e = (expQ.size() > 0) ? expQ.pop_front() : 18'h20000;
    ch = channelSelect;
    fork
      host.start_frame(edges, w);
      begin
        repeat (3) @(negedge ref_clk);
        check("powerDown", powerDown, 1'b0);
        check("resultInvalid", resultInvalid, !e[16]);
      end
    join
    if (edges >= 16 && e[17]) check("word", w, e[15:0]);
    if (edges >= 44)
    begin
      // Select stays low past the internal end of conversion, covering the full cycle
      repeat (4) @(negedge ref_clk);
      check("endOfConversion", endOfConversion, 1'b1);
      check("powerDown", powerDown, 1'b1);
      expQ.push_back({2'b11, hi ? CODE_FULL_SCALE : lo ? CODE_ZERO_SCALE : v, PAD_BITS});
    end
    else
      expQ.push_back(18'h00000);
    host.end_frame();
    if (dualVariant && edges >= 44) check("channelSelect", channelSelect, !ch);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("powerDown", powerDown, 1'b1);
    check("serialResultOutEn", serialResultOutEn, 1'b0);
    check("resultInvalid", resultInvalid, 1'b1);
    check("channelSelect", channelSelect, 1'b0);
    check("endOfConversion", endOfConversion, 1'b0);
    $display("test reset done");
  endtask

  // Each shift mode in turn, codes with alternating and edge bits
  task automatic t_modes();
    logic [2:0] m[4] = '{3'b000, 3'b100, 3'b010, 3'b001};
    logic [11:0] c[4] = '{12'ha5c, 12'h3f0, 12'h001, 12'hffe};
    int i;
    for (i = 0; i < 4; i++)
    begin
      {dspFrameMode, dualVariant, pseudoDiffVariant} = m[i];
      frame(44, c[i], 1'b0, 1'b0);
    end
    frame(44, 12'h800, 1'b0, 1'b0);
    $display("test modes done");
  endtask

  // One rising edge short of the minimum cycle aborts
  task automatic t_abort();
    {dspFrameMode, dualVariant, pseudoDiffVariant} = 3'b000;
    frame(43, 12'h555, 1'b0, 1'b0);
    frame(44, 12'h2aa, 1'b0, 1'b0);
    frame(44, 12'h7ff, 1'b0, 1'b0);
    $display("test abort done");
  endtask

  // Over-range, under-range, and both at once
  task automatic t_clamp();
    frame(44, 12'h7ff, 1'b1, 1'b0);
    frame(44, 12'h123, 1'b0, 1'b1);
    frame(44, 12'h456, 1'b1, 1'b1);
    frame(44, 12'h0f0, 1'b0, 1'b0);
    $display("test clamp done");
  endtask

  // Dual variant: toggle to channel one, then a short cycle resets it
  task automatic t_mux();
    {dspFrameMode, dualVariant, pseudoDiffVariant} = 3'b010;
    frame(44, 12'h321, 1'b0, 1'b0);
    if (channelSelect !== 1'b1) frame(44, 12'h654, 1'b0, 1'b0);
    frame(5, 12'h111, 1'b0, 1'b0);
    check("channelSelect", channelSelect, 1'b0);
    frame(44, 12'h987, 1'b0, 1'b0);
    frame(44, 12'h000, 1'b0, 1'b0);
    $display("test mux done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    t_reset();
    t_modes();
    t_abort();
    t_clamp();
    t_mux();
    end_sim();
  end

  // 17 cycles of at most some 190 ref cycles each; limit far beyond that
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    num_errors++;
    $display("watchdog expired");
    end_sim();
  end
endmodule
`default_nettype wire
